// ---- core/ude_cfg.svh ----
// Offsets, field positions, codes and reset values of the DMA/EOT block
`ifndef UDE_CFG_SVH
`define UDE_CFG_SVH
// ----------------------------------------
// Bus map (byte addresses)
// ----------------------------------------
`define UDE_OFF_DATA     12'h000
`define UDE_OFF_CMD      12'h004
`define UDE_OFF_STAT     12'h008
`define UDE_RESP_OKAY    2'h0
`define UDE_RESP_SLVERR  2'h2
`define UDE_RESP_DECERR  2'h3
// ----------------------------------------
// Command codes
// ----------------------------------------
`define UDE_CMD_EPCFG_WR 4'h2
`define UDE_CMD_EPCFG_RD 4'h3
`define UDE_CMD_HW_WR    8'hba
`define UDE_CMD_HW_RD    8'hbb
`define UDE_CMD_DCFG_WR  8'hf0
`define UDE_CMD_DCFG_RD  8'hf1
`define UDE_CMD_CNT_WR   8'hf2
`define UDE_CMD_CNT_RD   8'hf3
`define UDE_CMD_RESET    8'hf6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UDE_HW_ACKO      0
`define UDE_DC_RUN       0
`define UDE_DC_CNTR      1
`define UDE_DC_SHORT     2
`define UDE_DC_BURST_LSB 3
`define UDE_DC_BURST_MSB 5
`define UDE_DC_EP_LSB    8
`define UDE_DC_EP_MSB    11
`define UDE_EP_DIR       0
`define UDE_EP_ISO       1
`define UDE_ST_DONE      0
`define UDE_ST_CAUSE_LSB 1
`define UDE_ST_CNT_LSB   16
// ----------------------------------------
// Reset values
// ----------------------------------------
`define UDE_RST_HW       16'h0000
`define UDE_RST_DCFG     16'h0000
`define UDE_RST_CNT      16'h0000
`define UDE_RST_EP       8'h00
`define UDE_RST_CMD      8'h00
`endif

// ---- core/ude_pkg.sv ----
// Types shared by the DMA/EOT block
package ude_pkg;
  // DMA pins from the external controller
  typedef struct packed {
    logic        ack;
    logic        rd;
    logic        wr;
    logic        eot;
    logic [15:0] wdata;
  } ude_dma_in_t;
  // Endpoint buffer status toward the block
  typedef struct packed {
    logic        rd_avail;
    logic [15:0] rd_data;
    logic        wr_space;
    logic        short_rx;
    logic        eop;
  } ude_fifo_in_t;
  // Endpoint buffer commands from the block
  typedef struct packed {
    logic        pop;
    logic        push;
    logic [15:0] wdata;
    logic        discard;
    logic        validate;
    logic [15:0] pkt_len;
  } ude_fifo_out_t;
  // Decoded bus target
  typedef enum logic [1:0] {
    UDE_SEL_DATA, UDE_SEL_CMD, UDE_SEL_STAT, UDE_SEL_BAD
  } ude_sel_t;
endpackage

// ---- core/ude_dma_eot.sv ----
// DMA handshake, end-of-transfer control and command/data register access
// Function
// R1: ack-only select bit picks ack-only mode
// R2: ack-only mode: acknowledge is strobe, ignore rd/wr
// R3: bulk transfer ends on external end input
// R4: OUT end input discards current buffer only
// R5: IN end input validates buffer for next token
// R6: 16-bit byte count, used only when enabled
// R7: run enable rise loads internal counter
// R8: counter done raises end, stops DMA
// R9: short packet enable lets data set size
// R10: OUT short packet: move bytes then stop
// R11: IN short mode: counter zero mid-buffer ends
// R12: software clear of run stops, no event
// R13: isochronous endpoint also ends on USB EOP
// R14: software picks recommended iso end sources
// R15: command phase low byte, no-data commands immediate
// R16: data phase moves data, low word first
// R17: upper byte ignored in command; word access only
// R18: packet length kept; odd length tracked
// R19: endpoint config commands 22-2F write, 32-3F read; code also takes 20-21 write, 30-31 read
// R20: acknowledge selects endpoint from DMA index
// R21: direction from selected endpoint direction bit
// R22: request drops per word or after burst; burst count clears while ack is low, so longer bursts need ack held
// R23: request stays low after end until re-enable
`timescale 1ns/1ns
`include "ude_cfg.svh"
module ude_dma_eot #(
  parameter int BURST_MAX = 8
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // AXI4-Lite write address and data
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output      logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  input  wire logic [11:0]            s_axi_araddr,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  // DMA controller pins
  input  wire ude_pkg::ude_dma_in_t   dma_i,
  output      logic                   dev_dma_request,
  output      logic [15:0]            dma_rdata,
  output      logic [3:0]             dma_endpoint_sel,
  output      logic                   dma_eot_event,
  // Endpoint buffers
  input  wire ude_pkg::ude_fifo_in_t  fifo_i,
  output      ude_pkg::ude_fifo_out_t fifo_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (BURST_MAX < 1 || BURST_MAX > 8)
  begin : g_chk
    $error("BURST_MAX must be 1 to 8");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_held;
    logic                  w_held;
    ude_pkg::ude_sel_t     wsel;
    logic [15:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [7:0]            cmd;
    logic [15:0]           hw_config_reg;
    logic [15:0]           dma_config_reg;
    logic [15:0]           dma_byte_count_reg;
    logic [15:0][7:0]      endpoint_config_reg;
    logic [15:0]           cnt;
    logic [15:0]           in_len;
    logic                  done;
    logic [3:0]            cause;
    logic                  short_pend;
    logic                  strb_prev;
    logic                  hold;
    logic [2:0]            burst_cnt;
    logic                  req;
    logic [15:0]           dma_rdata;
    logic [3:0]            ep_sel;
    logic                  eot_ev;
    ude_pkg::ude_fifo_out_t fo;
  } ude_state_t;

  ude_state_t st_q;
  ude_state_t st_d;

  // Byte address to register target
  function automatic ude_pkg::ude_sel_t dec(
    input logic [11:0] a
  );
    unique case (a)
      `UDE_OFF_DATA: dec = ude_pkg::UDE_SEL_DATA;
      `UDE_OFF_CMD:  dec = ude_pkg::UDE_SEL_CMD;
      `UDE_OFF_STAT: dec = ude_pkg::UDE_SEL_STAT;
      default:       dec = ude_pkg::UDE_SEL_BAD;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        acko;
  logic        dir_in;
  logic        iso;
  logic        active;
  logic        strobe;
  logic        xfer;
  logic [15:0] step;
  logic [15:0] cnt_nx;
  logic [2:0]  bwords;
  logic        have;
  logic        e_ext;
  logic        e_cnt;
  logic        e_short;
  logic        e_eop;
  logic        run_rise;
  logic [15:0] rd_word;

  always_comb
  begin
    st_d            = st_q;
    st_d.eot_ev     = 1'b0;
    st_d.fo.pop     = 1'b0;
    st_d.fo.push    = 1'b0;
    st_d.fo.discard = 1'b0;
    st_d.fo.validate = 1'b0;
    run_rise        = 1'b0;
    rd_word         = 16'h0000;

    // Capture address and data separately, either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_held = 1'b1;
      st_d.wsel    = dec(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_held = 1'b1;
      st_d.wdata  = s_axi_wdata[15:0];
      st_d.wstrb  = s_axi_wstrb;
    end

    // Perform write once both halves are held
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
    begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `UDE_RESP_OKAY;
      unique case (st_q.wsel)
        ude_pkg::UDE_SEL_CMD:
        begin
          if (!st_q.wstrb[0])
            st_d.bresp = `UDE_RESP_SLVERR;
          else
          begin
            st_d.cmd = st_q.wdata[7:0]; // R15 R17
            if (st_q.wdata[7:0] == `UDE_CMD_RESET)
            begin
              // No data phase: acts at once
              st_d.hw_config_reg       = `UDE_RST_HW; // R15
              st_d.dma_config_reg      = `UDE_RST_DCFG;
              st_d.dma_byte_count_reg  = `UDE_RST_CNT;
              st_d.endpoint_config_reg = {16{`UDE_RST_EP}};
            end
          end
        end
        ude_pkg::UDE_SEL_DATA:
        begin
          // Strobes missing either low byte are refused
          if (st_q.wstrb[1:0] != 2'h3)
            st_d.bresp = `UDE_RESP_SLVERR; // R17
          else if (st_q.cmd[7:4] == `UDE_CMD_EPCFG_WR)
            st_d.endpoint_config_reg[st_q.cmd[3:0]] = st_q.wdata[7:0]; // R19 R16
          else if (st_q.cmd == `UDE_CMD_HW_WR)
            st_d.hw_config_reg = st_q.wdata; // R16
          else if (st_q.cmd == `UDE_CMD_CNT_WR)
            st_d.dma_byte_count_reg = st_q.wdata; // R6
          else if (st_q.cmd == `UDE_CMD_DCFG_WR)
          begin
            st_d.dma_config_reg = st_q.wdata;
            run_rise = st_q.wdata[`UDE_DC_RUN] & ~st_q.dma_config_reg[`UDE_DC_RUN];
          end
        end
        ude_pkg::UDE_SEL_STAT:
          st_d.bresp = `UDE_RESP_SLVERR;
        default:
          st_d.bresp = `UDE_RESP_DECERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;

    // Read: answer one cycle after the address is taken
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `UDE_RESP_OKAY;
      if (st_q.cmd[7:4] == `UDE_CMD_EPCFG_RD)
        rd_word = {8'h00, st_q.endpoint_config_reg[st_q.cmd[3:0]]}; // R19
      else if (st_q.cmd == `UDE_CMD_HW_RD)
        rd_word = st_q.hw_config_reg;
      else if (st_q.cmd == `UDE_CMD_DCFG_RD)
        rd_word = st_q.dma_config_reg;
      else if (st_q.cmd == `UDE_CMD_CNT_RD)
        rd_word = st_q.dma_byte_count_reg;
      unique case (dec(s_axi_araddr))
        ude_pkg::UDE_SEL_DATA: st_d.rdata = {16'h0000, rd_word};
        ude_pkg::UDE_SEL_CMD:  st_d.rdata = {24'h000000, st_q.cmd};
        ude_pkg::UDE_SEL_STAT:
          st_d.rdata = {st_q.cnt, 11'h000, st_q.cause, st_q.done};
        default:
        begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = `UDE_RESP_DECERR;
        end
      endcase
    end
    else if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;

    // Handshake readies follow the held state
    st_d.awready = ~st_d.aw_held & ~st_d.bvalid;
    st_d.wready  = ~st_d.w_held & ~st_d.bvalid;
    st_d.arready = ~st_d.rvalid;

    // Run enable rise restarts the transfer
    if (run_rise)
    begin
      st_d.cnt        = st_q.dma_byte_count_reg; // R7
      st_d.in_len     = 16'h0000;
      st_d.done       = 1'b0; // R23
      st_d.cause      = 4'h0;
      st_d.short_pend = 1'b0;
    end

    // Mode and endpoint decode
    acko   = st_q.hw_config_reg[`UDE_HW_ACKO]; // R1
    st_d.ep_sel = dma_i.ack ?
      st_q.dma_config_reg[`UDE_DC_EP_MSB:`UDE_DC_EP_LSB] : st_q.ep_sel; // R20
    dir_in = st_q.endpoint_config_reg[st_d.ep_sel][`UDE_EP_DIR]; // R21 R20
    iso    = st_q.endpoint_config_reg[st_d.ep_sel][`UDE_EP_ISO];
    active = st_q.dma_config_reg[`UDE_DC_RUN] & ~st_q.done; // R12

    // Strobe: ack alone, or rd/wr qualified by ack
    strobe = acko ? dma_i.ack : (dma_i.ack & (dir_in ? dma_i.wr : dma_i.rd)); // R2 R1
    st_d.strb_prev = strobe;
    xfer   = strobe & ~st_q.strb_prev & active & ~run_rise;

    // One word moves per strobe edge
    step   = (st_q.cnt == 16'h0001) ? 16'h0001 : 16'h0002;
    cnt_nx = st_q.cnt - step;
    if (xfer)
    begin
      st_d.cnt    = cnt_nx;
      st_d.in_len = st_q.in_len + step; // R18
      st_d.burst_cnt = st_q.burst_cnt + 3'h1;
      if (dir_in)
      begin
        st_d.fo.push  = 1'b1;
        st_d.fo.wdata = dma_i.wdata;
      end
      else
      begin
        st_d.fo.pop   = 1'b1;
        st_d.dma_rdata = fifo_i.rd_data;
      end
    end

    // Request drops per word with burst field 0, else at burst end only if ack stays high across the burst
    bwords = st_q.dma_config_reg[`UDE_DC_BURST_MSB:`UDE_DC_BURST_LSB];
    if (bwords > 3'(BURST_MAX - 1))
      bwords = 3'(BURST_MAX - 1);
    if (!dma_i.ack)
    begin
      st_d.hold      = 1'b0;
      st_d.burst_cnt = 3'h0;
    end
    else if (xfer && st_q.burst_cnt == bwords)
      st_d.hold = 1'b1; // R22

    // Short packet seen on an OUT endpoint
    if (fifo_i.short_rx && active && !dir_in &&
        st_q.dma_config_reg[`UDE_DC_SHORT])
      st_d.short_pend = 1'b1; // R9

    // End-of-transfer sources
    e_ext   = active & dma_i.eot; // R3
    e_cnt   = xfer & st_q.dma_config_reg[`UDE_DC_CNTR] & (cnt_nx == 16'h0000); // R6 R8
    e_short = active & st_q.dma_config_reg[`UDE_DC_SHORT] &
              (dir_in ? (xfer & (cnt_nx == 16'h0000)) // R11
                      : (st_q.short_pend & ~fifo_i.rd_avail & ~xfer)); // R10
    e_eop   = active & iso & fifo_i.eop; // R13

    // A same-cycle restart wins: every end source needs active, still low then
    if (e_ext || e_cnt || e_short || e_eop)
    begin
      st_d.done       = 1'b1; // R23
      st_d.cause      = {e_eop, e_short, e_cnt, e_ext};
      st_d.short_pend = 1'b0;
      st_d.eot_ev     = 1'b1;
      st_d.fo.discard = e_ext & ~dir_in; // R4
      if (dir_in)
      begin
        st_d.fo.validate = 1'b1; // R5
        st_d.fo.pkt_len  = st_d.in_len; // R18
        st_d.in_len      = 16'h0000;
      end
    end

    // Request only while data or room is there
    have     = dir_in ? fifo_i.wr_space : fifo_i.rd_avail;
    st_d.req = st_d.dma_config_reg[`UDE_DC_RUN] & ~st_d.done &
               have & ~st_d.hold & ~st_d.eot_ev; // R22 R23
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Synchronous reset clears all control state
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_q                     <= '0;
      st_q.hw_config_reg       <= `UDE_RST_HW;
      st_q.dma_config_reg      <= `UDE_RST_DCFG;
      st_q.dma_byte_count_reg  <= `UDE_RST_CNT;
      st_q.endpoint_config_reg <= {16{`UDE_RST_EP}};
      st_q.cmd                 <= `UDE_RST_CMD;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign s_axi_awready    = st_q.awready;
  assign s_axi_wready     = st_q.wready;
  assign s_axi_bvalid     = st_q.bvalid;
  assign s_axi_bresp      = st_q.bresp;
  assign s_axi_arready    = st_q.arready;
  assign s_axi_rvalid     = st_q.rvalid;
  assign s_axi_rdata      = st_q.rdata;
  assign s_axi_rresp      = st_q.rresp;
  assign dev_dma_request  = st_q.req;
  assign dma_rdata        = st_q.dma_rdata;
  assign dma_endpoint_sel = st_q.ep_sel;
  assign dma_eot_event    = st_q.eot_ev; // R12
  assign fifo_o           = st_q.fo;

endmodule // ude_dma_eot

// ---- dv/ude_dma_eot_monitor.sv ----
// Timing checker for the DMA/EOT block ports
`timescale 1ns/1ns
module ude_dma_eot_monitor #(
  parameter int BURST_MAX = 8
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  // Register bus
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [31:0]            s_axi_rdata,
  // DMA side
  input wire logic                   dev_dma_request,
  input wire logic                   dma_eot_event,
  input wire ude_pkg::ude_fifo_out_t fifo_o
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Write taken whole, then one idle cycle before the answer
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_resp_gap: assert property (s_wr_taken |=> s_b_late)
    else $error("write answer not two edges after handshake");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held after taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  a_eot_one_cycle: assert property (dma_eot_event |=> !dma_eot_event)
    else $error("end event longer than a cycle");
  a_req_quiet_end: assert property (dma_eot_event |=> !dev_dma_request [*3])
    else $error("request after end of transfer");
  a_push_per_word: assert property (fifo_o.push |=> !fifo_o.push)
    else $error("two pushes for one strobe");
endmodule // ude_dma_eot_monitor

bind ude_dma_eot ude_dma_eot_monitor #(.BURST_MAX(BURST_MAX)) u_ude_dma_eot_monitor (
  .clk_sys(clk_sys), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .dev_dma_request(dev_dma_request), .dma_eot_event(dma_eot_event), .fifo_o(fifo_o)
);

// ---- dv/ude_dma_ctl_model.sv ----
// Behavioural external DMA controller
`timescale 1ns/1ns
module ude_dma_ctl_model (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Bench controls
  input  wire logic                 ack_only,
  input  wire logic                 dir_in,
  input  wire logic [3:0]           slow,
  input  wire logic                 eot_req,
  // Block pins
  input  wire logic                 dev_dma_request,
  output      ude_pkg::ude_dma_in_t dma_o
);
  // ------------------------------
  // Strobe generator
  // ------------------------------
  logic [3:0]  gap_q;
  logic [15:0] word_q;
  // Gap after each strobe: request lags the word by an edge
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      dma_o  <= '0;
      gap_q  <= 4'h0;
      word_q <= 16'h0101;
    end
    else
    begin
      dma_o.eot <= eot_req;
      if (dma_o.ack)
      begin
        dma_o.ack   <= 1'b0;
        dma_o.rd    <= 1'b0;
        dma_o.wr    <= 1'b0;
        dma_o.wdata <= ~dma_o.wdata; // Released bus does not keep the word
        gap_q       <= 4'h0;
      end
      else if (dev_dma_request && gap_q >= slow + 4'h2)
      begin
        dma_o.ack   <= 1'b1;
        dma_o.rd    <= !ack_only && !dir_in;
        dma_o.wr    <= !ack_only && dir_in;
        dma_o.wdata <= word_q;
        word_q      <= word_q + 16'h0202;
      end
      else if (gap_q != 4'hf)
        gap_q <= gap_q + 4'h1;
    end
  end
endmodule // ude_dma_ctl_model

// ---- dv/ude_dma_eot_tb.sv ----
// Self-checking bench for the DMA/EOT block
`timescale 1ns/1ns
`include "ude_cfg.svh"
module ude_dma_eot_tb;
  logic                   clk_sys, rstn, awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry;
  logic                   req, eotev, ack_only, dir_in, eot_req;
  logic [11:0]            awa, ara;
  logic [31:0]            wd, rdq;
  logic [1:0]             br, rr;
  logic [3:0]             slow, epsel, ws;
  logic [15:0]            rdat;
  ude_pkg::ude_dma_in_t   dma;
  ude_pkg::ude_fifo_in_t  fin;
  ude_pkg::ude_fifo_out_t fout;
  logic [31:0]            n_pop = '0, n_push = '0, n_val = '0, n_dis = '0, n_eot = '0, len_q = '0;
  int                     bad_count = 0, n_checks = 0;

  ude_dma_eot #(.BURST_MAX(8)) u_ude_dma_eot (
    .clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdq), .s_axi_rresp(rr),
    .dma_i(dma), .dev_dma_request(req), .dma_rdata(rdat),
    .dma_endpoint_sel(epsel), .dma_eot_event(eotev), .fifo_i(fin), .fifo_o(fout)
  );
  ude_dma_ctl_model u_ude_dma_ctl_model (
    .clk_sys(clk_sys), .rstn(rstn), .ack_only(ack_only), .dir_in(dir_in), .slow(slow),
    .eot_req(eot_req), .dev_dma_request(req), .dma_o(dma)
  );
  // ------------------------------
  // Clock, pulse counters, checks
  // ------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Counted on the falling edge, clear of the driving edge
  always @(negedge clk_sys)
  begin
    n_pop  <= n_pop + fout.pop;
    n_push <= n_push + fout.push;
    n_val  <= n_val + fout.validate;
    n_dis  <= n_dis + fout.discard;
    n_eot  <= n_eot + eotev;
    if (fout.validate === 1'b1)
      len_q <= {16'h0, fout.pkt_len};
    // Model inverts its word once taken, so the pushed word is its inverse
    if (fout.push === 1'b1)
      chk("push word", {16'h0, ~dma.wdata}, {16'h0, fout.wdata});
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for a counter to reach a value
  task automatic wait_cnt(ref logic [31:0] c, input logic [31:0] v);
    for (int i = 0; i < 400 && c < v; i++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask
  // ------------------------------
  // Bus master
  // ------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end while (!bv);
    r = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arr)
        arv <= 1'b0;
    end while (!rv);
    d = rdq;
    r = rr;
    rry <= 1'b0;
  endtask
  task automatic reg_w(input logic [7:0] c, input logic [15:0] v);
    logic [1:0] r;
    wr(`UDE_OFF_CMD, {24'h0, c}, r);
    wr(`UDE_OFF_DATA, {16'h0, v}, r);
  endtask
  task automatic reg_r(input logic [7:0] c, output logic [31:0] d);
    logic [1:0] r;
    wr(`UDE_OFF_CMD, {24'h0, c}, r);
    rd(`UDE_OFF_DATA, d, r);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    reg_w(`UDE_CMD_CNT_WR, 16'hbeef);
    reg_r(`UDE_CMD_CNT_RD, d);
    chk("byte count", 32'h0000beef, d);
    reg_w(8'h2f, 16'h0003);
    reg_r(8'h3f, d);
    chk("last endpoint config", 32'h3, d);
    wr(`UDE_OFF_CMD, {16'h0, 8'hff, `UDE_CMD_RESET}, r);
    reg_r(`UDE_CMD_CNT_RD, d);
    chk("count after reset command", 32'h0, d);
    rd(12'h00c, d, r);
    chk("unmapped read resp", {30'h0, `UDE_RESP_DECERR}, {30'h0, r});
    ws <= 4'h1;
    wr(`UDE_OFF_DATA, 32'h0, r);
    chk("byte write resp", {30'h0, `UDE_RESP_SLVERR}, {30'h0, r});
    ws <= 4'hf;
  endtask
  task automatic t_out_cnt();
    logic [31:0] p0, u0, e0;
    p0 = n_pop;
    u0 = n_push;
    e0 = n_eot;
    ack_only        <= 1'b1;
    fin.rd_avail    <= 1'b1;
    fin.rd_data     <= 16'h5a3c;
    reg_w(`UDE_CMD_HW_WR, 16'h0001);
    reg_w(8'h22, 16'h0000);
    reg_w(`UDE_CMD_CNT_WR, 16'h0006);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0203);
    wait_cnt(n_eot, e0 + 1);
    chk("out pops", p0 + 3, n_pop);
    chk("no pushes on out", u0, n_push);
    chk("end events", e0 + 1, n_eot);
    chk("request after end", 32'h0, {31'h0, req});
    chk("dma endpoint", 32'h2, {28'h0, epsel});
    chk("out word", 32'h5a3c, {16'h0, rdat});
  endtask
  task automatic t_in_eot();
    logic [31:0] u0, p0, e0, v0;
    u0 = n_push;
    p0 = n_pop;
    e0 = n_eot;
    v0 = n_val;
    ack_only     <= 1'b0;
    dir_in       <= 1'b1;
    slow         <= 4'h4;
    fin.rd_avail <= 1'b0;
    fin.wr_space <= 1'b1;
    reg_w(`UDE_CMD_HW_WR, 16'h0000);
    reg_w(8'h22, 16'h0001);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0200);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0201);
    wait_cnt(n_push, u0 + 3);
    eot_req <= 1'b1;
    @(posedge clk_sys);
    eot_req <= 1'b0;
    wait_cnt(n_eot, e0 + 1);
    chk("end on input", e0 + 1, n_eot);
    chk("in validate", v0 + 1, n_val);
    chk("packet length", (n_push - u0) << 1, len_q);
    chk("no pops on in", p0, n_pop);
  endtask
  task automatic t_out_stop();
    logic [31:0] e0, d0;
    e0 = n_eot;
    d0 = n_dis;
    ack_only     <= 1'b1;
    dir_in       <= 1'b0;
    slow         <= 4'h6;
    fin.rd_avail <= 1'b1;
    reg_w(`UDE_CMD_HW_WR, 16'h0001);
    reg_w(8'h22, 16'h0000);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0200);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0201);
    wait_cnt(n_pop, n_pop + 1);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0200);
    chk("event on run clear", e0, n_eot);
    chk("request on run clear", 32'h0, {31'h0, req});
    reg_w(`UDE_CMD_DCFG_WR, 16'h0201);
    wait_cnt(n_pop, n_pop + 1);
    eot_req <= 1'b1;
    @(posedge clk_sys);
    eot_req <= 1'b0;
    wait_cnt(n_eot, e0 + 1);
    chk("out discard", d0 + 1, n_dis);
  endtask
  task automatic t_out_short();
    logic [31:0] e0, d;
    logic [1:0]  r;
    e0 = n_eot;
    reg_w(8'h22, 16'h0000);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0200);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0205);
    wait_cnt(n_pop, n_pop + 1);
    fin.short_rx <= 1'b1;
    @(posedge clk_sys);
    fin.short_rx <= 1'b0;
    wait_cnt(n_pop, n_pop + 1);
    fin.rd_avail <= 1'b0;
    wait_cnt(n_eot, e0 + 1);
    rd(`UDE_OFF_STAT, d, r);
    chk("short end cause", 32'h9, {27'h0, d[4:0]});
    fin.rd_avail <= 1'b1;
  endtask
  task automatic t_iso_eop();
    logic [31:0] e0, d;
    logic [1:0]  r;
    e0 = n_eot;
    reg_w(8'h22, 16'h0003);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0200);
    reg_w(`UDE_CMD_DCFG_WR, 16'h0201);
    wait_cnt(n_pop, n_pop + 1);
    fin.eop <= 1'b1;
    @(posedge clk_sys);
    fin.eop <= 1'b0;
    wait_cnt(n_eot, e0 + 1);
    rd(`UDE_OFF_STAT, d, r);
    chk("iso end cause", 32'h11, {27'h0, d[4:0]});
  endtask
  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial
  begin
    {awv, wv, bry, arv, rry, ack_only, dir_in, eot_req} = '0;
    {awa, ara, wd, slow} = '0;
    ws   = 4'hf;
    fin = '0;
    rstn = 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_out_cnt();
    t_in_eot();
    t_out_stop();
    t_out_short();
    t_iso_eop();
    final_report();
  end
  // Whole run needs a few thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
endmodule // ude_dma_eot_tb
